// ==== sdc_checker.sv ====
// Checker for the serial data and CRC block, sees the top ports only.
// Assumes one clock domain and APB transfers with zero wait states.
`timescale 1ns/1ns
module sdc_checker (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        link_sck,
   input wire logic        link_sel_b,
   input wire logic        link_din,
   input wire logic        link_dout,
   input wire logic        audio_channel_length_sel_32,
   input wire logic [1:0]  audio_width
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic        acc;
   logic        wr;
   logic        aen_reg;
   logic        cen_reg;
   logic        fresh_reg;
   logic [15:0] poly_reg;
   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite;
   // Shadow copies; fresh marks CRCs known zero until a frame starts
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         aen_reg   <= 1'b0;
         cen_reg   <= 1'b0;
         fresh_reg <= 1'b1;
         poly_reg  <= sdc_pkg::POLY_RESET;
      end else begin
         if (wr && paddr == sdc_pkg::OFS_CTRL) begin
            aen_reg <= pwdata[sdc_pkg::CTRL_AUDIO_EN];
            cen_reg <= pwdata[sdc_pkg::CTRL_CRC_EN];
         end
         if (wr && paddr == sdc_pkg::OFS_POLY) begin
            poly_reg <= pwdata[15:0];
         end
         if (!link_sel_b) begin
            fresh_reg <= 1'b0;
         end else if (wr && paddr == sdc_pkg::OFS_CTRL && pwdata[0] && !cen_reg) begin
            fresh_reg <= 1'b1;
         end
      end
   end
   pready_answer_a: assert property (psel && !penable |=> pready)
      else $error("access phase without ready");
   upper_zero_a: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   poly_read_a: assert property (acc && !pwrite && paddr == sdc_pkg::OFS_POLY |-> prdata == {16'h0000, poly_reg})
      else $error("polynomial readback wrong");
   crc_clear_a: assert property (acc && !pwrite && fresh_reg && paddr inside {8'h14, 8'h18} |-> prdata == 32'h0)
      else $error("crc not cleared");
   channel_length_sel_write_a: assert property (wr && paddr == 8'h1C && !aen_reg && pwdata[2:1] == 2'h0
      |=> audio_channel_length_sel_32 == $past(pwdata[0]))
      else $error("channel length not taken");
   channel_length_sel_forced_a: assert property (audio_width != 2'h0 |-> audio_channel_length_sel_32)
      else $error("channel length not forced");
   width_write_a: assert property (wr && paddr == 8'h1C && !aen_reg |=> audio_width == $past(pwdata[2:1]))
      else $error("sample width not taken");
   audio_frozen_a: assert property (aen_reg |=> $stable(audio_width) && $stable(audio_channel_length_sel_32))
      else $error("audio lengths changed while enabled");
   cover property (wr && paddr == 8'h1C && aen_reg);
   cover property (acc && !pwrite && paddr == 8'h14 && !fresh_reg);
   cover property (audio_width == sdc_pkg::DLEN_32 && audio_channel_length_sel_32);
endmodule

// ==== sdc_fifo.sv ====
// Synchronous FIFO in flip-flops, valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module sdc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } sdc_fifo_st_t;
   sdc_fifo_st_t st_reg;
   sdc_fifo_st_t st_next;
   logic         push;
   logic         pop;

   assign in_ready  = (st_reg.cnt != DEPTH[AW:0]);
   assign out_valid = (st_reg.cnt != '0);
   assign out_data  = st_reg.mem[st_reg.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wp] = in_data;
         st_next.wp             = st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// ==== sdc_link_master.sv ====
// Link master model: frames with select low, clock still between frames.
// Assumes the block samples rising and shifts after falling clock edges.
`timescale 1ns/1ns
module sdc_link_master (
   output logic      link_sck,
   output logic      link_sel_b,
   output logic      link_din,
   input  wire logic link_dout
);
   initial begin
      link_sck   = 1'b0;
      link_sel_b = 1'b1;
      link_din   = 1'b0;
   end
   task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      // Keeps every pin change off the core clock edges
      #20 link_sel_b = 1'b0;
      #800;
      for (int i = n - 1; i >= 0; i--) begin
         link_din = tx[i];
         #400 link_sck = 1'b1;
         rx[i] = link_dout;
         #400 link_sck = 1'b0;
      end
      #800 link_sel_b = 1'b1;
      link_din = ~link_din; // Released line keeps no stale level
      // Idle gap so the block sees select high between frames
      #800;
   endtask
endmodule

// ==== sdc_pkg.sv ====
// Package for the SPI/audio data path and CRC block: register map, fields, reset values.
// Assumes a 32-bit APB slave with word-aligned registers.
package sdc_pkg;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h08;
   localparam logic [7:0]  OFS_DATA      = 8'h0C;
   localparam logic [7:0]  OFS_POLY      = 8'h10;
   localparam logic [7:0]  OFS_RECEIVE_CRC_RESULT     = 8'h14;
   localparam logic [7:0]  OFS_TRANSMIT_CRC_RESULT     = 8'h18;
   localparam logic [7:0]  OFS_AUDIO     = 8'h1C;
   localparam logic [15:0] POLY_RESET    = 16'h0007;
   localparam logic [15:0] CRC_RESET     = 16'h0000;
   localparam logic [15:0] DATA_RESET    = 16'h0000;
   localparam logic [15:0] AUDIO_RESET   = 16'h0000;
   localparam int          CTRL_CRC_EN   = 0;
   localparam int          CTRL_WIDE     = 1;
   localparam int          CTRL_CRC_NEXT = 2;
   localparam int          CTRL_AUDIO_EN = 3;
   localparam int          CTRL_CPOL     = 4;
   localparam int          ST_RX_NE      = 0;
   localparam int          ST_TX_NF      = 1;
   localparam int          ST_CRC_ERR    = 4;
   localparam int          ST_BUSY       = 7;
   localparam int          AUD_CHANNEL_LENGTH_SEL     = 0;
   localparam int          AUD_DLEN_LO   = 1;
   localparam int          AUD_DLEN_HI   = 2;
   localparam logic [1:0]  DLEN_16       = 2'h0;
   localparam logic [1:0]  DLEN_24       = 2'h1;
   localparam logic [1:0]  DLEN_32       = 2'h2;
   localparam int          FIFO_DEPTH    = 32;
   localparam int          FIFO_WIDTH    = 16;
endpackage

// ==== sdc_tb_top.sv ====
// Testbench for the serial data and CRC block: APB master, queue scoreboard.
// Assumes the link master model and the checker bound to the top.
`timescale 1ns/1ns
module sdc_tb_top;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, link_sck, link_sel_b, link_din, link_dout, audio_channel_length_sel_32;
   logic [1:0]  audio_width;
   logic [63:0] exp_q[$];
   logic [63:0] ent;
   logic [15:0] poly, crc_r, crc_t, tx_v, rx_v, got, msk;
   int          err_total = 0;
   int          check_count = 0;
   int          cyc = 0;
   always #50 core_clk = ~core_clk;
   sdc_top uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_sck(link_sck), .link_sel_b(link_sel_b), .link_din(link_din), .link_dout(link_dout),
      .audio_channel_length_sel_32(audio_channel_length_sel_32), .audio_width(audio_width));
   sdc_link_master lnk (.link_sck(link_sck), .link_sel_b(link_sel_b), .link_din(link_din), .link_dout(link_dout));
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Idle edge after each transfer keeps one assignment per time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      exp_q.push_back({m, e});
      apb(1'b0, a, 32'h0);
   endtask
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] v, input int n);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = n - 1; i >= 0; i--) begin
         fb = r[n-1] ^ v[i];
         r = (r << 1) ^ (fb ? poly : 16'h0000);
      end
      return (n == 8) ? {8'h00, r[7:0]} : r;
   endfunction
   always @(posedge core_clk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         ent = exp_q.pop_front();
         cmp("prdata", ent[31:0] & ent[63:32], prdata & ent[63:32]);
      end
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 12000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      void'($urandom(69924));
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rd(sdc_pkg::OFS_POLY, 32'hFFFFFFFF, 32'(sdc_pkg::POLY_RESET));
      rd(sdc_pkg::OFS_TRANSMIT_CRC_RESULT, 32'hFFFFFFFF, 32'(sdc_pkg::CRC_RESET));
      rd(sdc_pkg::OFS_DATA, 32'hFFFFFFFF, 32'(sdc_pkg::DATA_RESET));
      rd(8'h24, 32'hFFFFFFFF, 32'h0);
      poly = 16'($urandom);
      wr(sdc_pkg::OFS_POLY, {16'hFFFF, poly});
      rd(sdc_pkg::OFS_POLY, 32'hFFFFFFFF, {16'h0000, poly});
      for (int v = 0; v < 8; v++) begin
         wr(sdc_pkg::OFS_AUDIO, 32'(v));
         cmp("audio_width", 32'(v[2:1]), 32'(audio_width));
         cmp("audio_channel_length_sel", 32'(v[0] | (v[2:1] != 0)), 32'(audio_channel_length_sel_32));
      end
      wr(sdc_pkg::OFS_CTRL, 32'h8);
      wr(sdc_pkg::OFS_AUDIO, 32'h0);
      cmp("audio_width", 32'h3, 32'(audio_width));
      wr(sdc_pkg::OFS_CTRL, 32'h0);
      for (int wide = 0; wide < 2; wide++) begin
         msk = wide ? 16'hFFFF : 16'h00FF;
         wr(sdc_pkg::OFS_CTRL, 32'h0);
         wr(sdc_pkg::OFS_CTRL, 32'(2 * wide + 1));
         rd(sdc_pkg::OFS_RECEIVE_CRC_RESULT, 32'hFFFFFFFF, 32'h0);
         crc_r = 16'h0000;
         crc_t = 16'h0000;
         for (int k = 0; k < 3; k++) begin
            // CRC word may only follow the last data frame
            if (k == 2) begin
               wr(sdc_pkg::OFS_CTRL, 32'(2 * wide + 5));
            end
            tx_v = 16'($urandom);
            rx_v = 16'($urandom);
            wr(sdc_pkg::OFS_DATA, {16'h0000, tx_v});
            lnk.frame(rx_v, 8 + 8 * wide, got);
            repeat (10) @(posedge core_clk);
            cmp("link_dout", 32'(tx_v & msk), 32'(got));
            crc_r = crc_step(crc_r, rx_v, 8 + 8 * wide);
            crc_t = crc_step(crc_t, tx_v, 8 + 8 * wide);
            rd(sdc_pkg::OFS_DATA, 32'(msk), 32'(rx_v & msk));
         end
         rd(sdc_pkg::OFS_RECEIVE_CRC_RESULT, 32'(msk), 32'(crc_r));
         rd(sdc_pkg::OFS_TRANSMIT_CRC_RESULT, 32'(msk), 32'(crc_t));
         lnk.frame((crc_r ^ 16'h0001) & msk, 8 + 8 * wide, got);
         repeat (10) @(posedge core_clk);
         cmp("crc_dout", 32'(crc_t), 32'(got & msk));
         rd(sdc_pkg::OFS_STATUS, 32'h10, 32'h10);
         rd(sdc_pkg::OFS_DATA, 32'(msk), 32'(rx_v & msk));
         wr(sdc_pkg::OFS_STATUS, 32'h0);
         rd(sdc_pkg::OFS_STATUS, 32'h10, 32'h0);
      end
      wr(sdc_pkg::OFS_CTRL, 32'h0);
      repeat (31) wr(sdc_pkg::OFS_DATA, $urandom);
      rd(sdc_pkg::OFS_STATUS, 32'h2, 32'h2);
      repeat (2) wr(sdc_pkg::OFS_DATA, $urandom);
      rd(sdc_pkg::OFS_STATUS, 32'h2, 32'h0);
      repeat (32) begin
         @(posedge core_clk);
         lnk.frame(16'h0000, 8, got);
      end
      repeat (10) @(posedge core_clk);
      rd(sdc_pkg::OFS_STATUS, 32'h2, 32'h2);
      conclude();
   end
endmodule
bind sdc_top sdc_checker chk (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .link_sck(link_sck), .link_sel_b(link_sel_b), .link_din(link_din), .link_dout(link_dout),
   .audio_channel_length_sel_32(audio_channel_length_sel_32), .audio_width(audio_width));

// ==== sdc_top.sv ====
// Serial data path with programmable CRC and audio length configuration, APB slave.
// Assumes an external link master driving serial clock, select and data-in pins.
// Summary of operation
// - Data write feeds transmit, read drains receive
// - Narrow frames use low byte only
// - Polynomial register writable, resets to 0x0007
// - Receive CRC, 8 or 16 bit
// - Setting CRC enable clears receive CRC
// - Transmit CRC, resets zero, width follows frame
// - Channel length bit: 16 or 32
// - Channel length forced 32 unless width 16
// - Sample width 16, 24, 32; 11 illegal
// - Audio lengths writable only while disabled
// - CRC word mismatch sets error flag
`timescale 1ns/1ns
module sdc_top (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        link_sck,
   input  wire logic        link_sel_b,
   input  wire logic        link_din,
   output logic             link_dout,
   output logic             audio_channel_length_sel_32,
   output logic      [1:0]  audio_width
);
   typedef enum logic [1:0] {SDC_IDLE, SDC_SHIFT} sdc_state_t;
   typedef struct packed {
      sdc_state_t  state;
      logic [2:0]  sck_s;
      logic [1:0]  sel_s;
      logic [1:0]  din_s;
      logic [15:0] poly;
      logic [15:0] rx_crc;
      logic [15:0] tx_crc;
      logic [4:0]  ctrl;
      logic        channel_length_sel;
      logic [1:0]  dlen;
      logic        crc_err;
      logic [15:0] rx_data;
      logic        rx_full;
      logic [15:0] tx_sh;
      logic [15:0] rx_sh;
      logic [4:0]  bit_cnt;
      logic        crc_phase;
      logic        dout;
      logic [31:0] rdata;
   } sdc_st_t;

   sdc_st_t     st_reg;
   sdc_st_t     st_next;
   logic        wr_acc;
   logic        rd_acc;
   logic [15:0] fifo_out;
   logic        fifo_valid;
   logic        fifo_ready;
   logic        fifo_pop;
   logic        sck_rise;
   logic        sck_fall;
   logic        wide;
   logic [4:0]  frame_bits;
   logic [15:0] mask;

   // CRC step over one bit, polynomial cut to the frame width
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din,
                                            input logic [15:0] poly, input logic w);
      logic fb;
      logic [15:0] r;
      fb = din ^ (w ? crc[15] : crc[7]);
      r  = {crc[14:0], 1'b0};
      if (fb) begin
         r = r ^ poly;
      end
      crc_step = w ? r : {8'h00, r[7:0]};
   endfunction

   // Register select decoded once per cycle for both read and write paths
   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
      is_reg = (a == ofs);
   endfunction

   assign pready     = 1'b1;
   assign pslverr    = 1'b0;
   assign wr_acc     = psel && penable && pwrite;
   assign rd_acc     = psel && penable && !pwrite;
   assign prdata     = st_reg.rdata;
   assign link_dout  = st_reg.dout;
   assign wide       = st_reg.ctrl[sdc_pkg::CTRL_WIDE];
   assign frame_bits = wide ? 5'd16 : 5'd8;
   assign mask       = wide ? 16'hFFFF : 16'h00FF;
   // Only the second and third sync stages feed the edge detector
   assign sck_rise   = st_reg.sck_s[1] && !st_reg.sck_s[2];
   assign sck_fall   = !st_reg.sck_s[1] && st_reg.sck_s[2];
   assign audio_channel_length_sel_32 = st_reg.channel_length_sel;
   assign audio_width    = st_reg.dlen;

   sdc_fifo #(
      .WIDTH (sdc_pkg::FIFO_WIDTH),
      .DEPTH (sdc_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .in_data   (pwdata[15:0] & mask),
      .in_valid  (wr_acc && is_reg(paddr, sdc_pkg::OFS_DATA)),
      .in_ready  (fifo_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   assign fifo_pop = (st_reg.state == SDC_IDLE) && !st_reg.sel_s[1] && fifo_valid && !st_reg.crc_phase;

   always_comb begin
      st_next       = st_reg;
      st_next.sck_s = {st_reg.sck_s[1:0], link_sck};
      st_next.sel_s = {st_reg.sel_s[0], link_sel_b};
      st_next.din_s = {st_reg.din_s[0], link_din};

      if (wr_acc) begin
         if (is_reg(paddr, sdc_pkg::OFS_POLY)) begin
            st_next.poly = pwdata[15:0];
         end
         if (is_reg(paddr, sdc_pkg::OFS_CTRL)) begin
            st_next.ctrl = pwdata[4:0];
            if (pwdata[sdc_pkg::CTRL_CRC_EN] && !st_reg.ctrl[sdc_pkg::CTRL_CRC_EN]) begin
               st_next.rx_crc = sdc_pkg::CRC_RESET;
               st_next.tx_crc = sdc_pkg::CRC_RESET;
            end
         end
         if (is_reg(paddr, sdc_pkg::OFS_AUDIO) && !st_reg.ctrl[sdc_pkg::CTRL_AUDIO_EN]) begin
            st_next.dlen = pwdata[sdc_pkg::AUD_DLEN_HI:sdc_pkg::AUD_DLEN_LO];
            if (pwdata[sdc_pkg::AUD_DLEN_HI:sdc_pkg::AUD_DLEN_LO] == sdc_pkg::DLEN_16) begin
               st_next.channel_length_sel = pwdata[sdc_pkg::AUD_CHANNEL_LENGTH_SEL];
            end else begin
               st_next.channel_length_sel = 1'b1;
            end
         end
         if (is_reg(paddr, sdc_pkg::OFS_STATUS) && !pwdata[sdc_pkg::ST_CRC_ERR]) begin
            st_next.crc_err = 1'b0;
         end
      end

      if (rd_acc && is_reg(paddr, sdc_pkg::OFS_DATA)) begin
         st_next.rx_full = 1'b0;
      end

      if (fifo_pop) begin
         st_next.tx_sh   = fifo_out;
         st_next.state   = SDC_SHIFT;
         st_next.bit_cnt = 5'd0;
         st_next.dout    = wide ? fifo_out[15] : fifo_out[7];
      end else if ((st_reg.state == SDC_IDLE) && st_reg.crc_phase && !st_reg.sel_s[1]) begin
         // Trailing CRC word is shifted in place of data
         st_next.tx_sh   = st_reg.tx_crc;
         st_next.state   = SDC_SHIFT;
         st_next.bit_cnt = 5'd0;
         st_next.dout    = wide ? st_reg.tx_crc[15] : st_reg.tx_crc[7];
      end

      case (st_reg.state)
         SDC_IDLE: begin
         end
         SDC_SHIFT: begin
            if (st_reg.sel_s[1]) begin
               // Select dropped mid-frame: abandon it
               st_next.state = SDC_IDLE;
            end else if (sck_rise) begin
               st_next.rx_sh = {st_reg.rx_sh[14:0], st_reg.din_s[1]} & mask;
               if (st_reg.ctrl[sdc_pkg::CTRL_CRC_EN] && !st_reg.crc_phase) begin
                  st_next.rx_crc = crc_step(st_reg.rx_crc, st_reg.din_s[1], st_reg.poly, wide);
                  st_next.tx_crc = crc_step(st_reg.tx_crc, wide ? st_reg.tx_sh[15] : st_reg.tx_sh[7],
                                            st_reg.poly, wide);
               end
               st_next.tx_sh   = {st_reg.tx_sh[14:0], 1'b0};
               st_next.bit_cnt = st_reg.bit_cnt + 5'd1;
               if (st_reg.bit_cnt + 5'd1 == frame_bits) begin
                  st_next.state = SDC_IDLE;
                  if (st_reg.crc_phase) begin
                     st_next.crc_phase = 1'b0;
                     if (((({st_reg.rx_sh[14:0], st_reg.din_s[1]}) ^ st_reg.rx_crc) & mask) != 16'h0000) begin
                        st_next.crc_err = 1'b1;
                     end
                  end else begin
                     st_next.rx_data = {st_reg.rx_sh[14:0], st_reg.din_s[1]} & mask;
                     st_next.rx_full = 1'b1;
                     if (st_reg.ctrl[sdc_pkg::CTRL_CRC_NEXT] && !fifo_valid) begin
                        st_next.crc_phase = 1'b1;
                     end
                  end
               end
            end else if (sck_fall) begin
               st_next.dout = wide ? st_reg.tx_sh[15] : st_reg.tx_sh[7];
            end
         end
         default: begin
            st_next.state = SDC_IDLE;
         end
      endcase

      st_next.rdata = 32'h0000_0000;
      if (rd_acc || (psel && !penable && !pwrite)) begin
         case (paddr)
            sdc_pkg::OFS_CTRL:   st_next.rdata = {27'h0, st_reg.ctrl};
            sdc_pkg::OFS_STATUS: st_next.rdata = {24'h0, (st_reg.state == SDC_SHIFT), 2'h0, st_reg.crc_err,
                                                  2'h0, fifo_ready, st_reg.rx_full};
            sdc_pkg::OFS_DATA:   st_next.rdata = {16'h0, st_reg.rx_data};
            sdc_pkg::OFS_POLY:   st_next.rdata = {16'h0, st_reg.poly};
            sdc_pkg::OFS_RECEIVE_CRC_RESULT:  st_next.rdata = {16'h0, st_reg.rx_crc};
            sdc_pkg::OFS_TRANSMIT_CRC_RESULT:  st_next.rdata = {16'h0, st_reg.tx_crc};
            sdc_pkg::OFS_AUDIO:  st_next.rdata = {29'h0, st_reg.dlen, st_reg.channel_length_sel};
            default:             st_next.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc && is_reg(paddr, sdc_pkg::OFS_STATUS) && st_next.crc_err && st_reg.crc_err) begin
         st_next.crc_err = st_next.crc_err;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg         <= '0;
         st_reg.state   <= SDC_IDLE;
         st_reg.sel_s   <= 2'h3;
         st_reg.poly    <= sdc_pkg::POLY_RESET;
         st_reg.tx_crc  <= sdc_pkg::CRC_RESET;
         st_reg.rx_crc  <= sdc_pkg::CRC_RESET;
         st_reg.rx_data <= sdc_pkg::DATA_RESET;
         {st_reg.dlen, st_reg.channel_length_sel} <= sdc_pkg::AUDIO_RESET[2:0];
      end else begin
         st_reg <= st_next;
      end
   end
endmodule
